// ---- hdl/ims_baud.sv ----
// Shared constants of the I2C master sequencer and its baud counter.
`timescale 1ns/1ns

package ims_pkg;
    // ****************************************************************
    // Widths, control bit positions, and counter and reset values
    // ****************************************************************
    localparam int BAUD_W = 7;
    localparam int CTL2_W = 5;
    localparam int CTL_START_BIT = 0;
    localparam int CTL_RESTART_BIT = 1;
    localparam int BYTE_W = 8;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
    localparam logic [3:0] BIT_CNT_ONE = 4'h1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [6:0] BAUD_ZERO = 7'h00;
    localparam logic [6:0] BAUD_ONE = 7'h01;

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_S_WAIT = 4'h1,
        ST_S_HOLD = 4'h2,
        ST_R_SCLLO = 4'h3,
        ST_R_SDAHI = 4'h4,
        ST_R_SCLREL = 4'h5,
        ST_R_BOTHHI = 4'h6,
        ST_R_SDALO = 4'h7,
        ST_T_LOW = 4'h8,
        ST_T_REL = 4'h9,
        ST_T_HIGH = 4'hA
    } ims_state_t;
endpackage

module ims_baud
    import ims_pkg::*;
#(
    parameter int W = BAUD_W
) (
    input wire logic i_clk,           // System clock.
    input wire logic i_rst,           // Synchronous reset, active high.
    input wire logic i_load,          // Reload the count and start.
    input wire logic i_stop,          // Abort the count.
    input wire logic [W-1:0] i_reload, // Reload value.
    output logic o_expire              // One-cycle pulse at count end.
);
    // ****************************************************************
    // Down counter that halts at zero
    // ****************************************************************
    logic [W-1:0] cnt_q;
    logic act_q;

    assign o_expire = act_q && (cnt_q == W'(BAUD_ZERO));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= W'(BAUD_ZERO);
            act_q <= 1'b0;
        end else if (i_stop) begin
            act_q <= 1'b0;
        end else if (i_load) begin
            cnt_q <= i_reload;                                 // R21
            act_q <= 1'b1;
        end else if (o_expire) begin
            act_q <= 1'b0;                                     // R21
        end else if (act_q) begin
            cnt_q <= cnt_q - W'(BAUD_ONE);                     // R21
        end
    end
endmodule

// ---- hdl/ims_seq.sv ----
// I2C master start, repeated start and byte transmit sequencer.
// Notes on behaviour
// (R1) Start request checks both lines high, loads baud counter, starts counting.
// (R2) At expiry with both lines high, SDA driven low and start_seen set.
// (R3) Second expiry clears start_enable, stops counter, keeps SDA low.
// (R4) Low line at start or SCL low before SDA low: collision, abort, idle.
// (R5) Buffer write during start is dropped and sets write_collision.
// (R6) Control writes are ignored until a start or restart completes.
// (R7) Restart in idle pulls SCL low, then releases SDA for one period.
// (R8) SDA high: release SCL, wait high, both high one period, SDA low.
// (R9) Restart end clears restart_enable, no reload, sets flags as specified.
// (R10) Restart request during another event is ignored.
// (R11) Restart collision: SDA low as SCL rises, or SCL drops early.
// (R12) Buffer write during restart is dropped and sets write_collision.
// (R13) Accepted buffer write sets buffer_full and starts the byte.
// (R14) Each bit changes with SCL low; SCL low then high one period each.
// (R15) buffer_full clears once eight bits have been shifted out.
// (R16) After the eighth falling edge SDA is released for the acknowledge.
// (R17) SDA sampled on ninth falling edge into ack_status.
// (R18) After ninth clock event flag set, counter stops, SCL held low.
// (R19) Buffer write while shifting is dropped; write_collision stays until cleared.
// (R20) Software writes address after the start event, then data after acknowledge.
// (R21) Baud counter loads seven bits, counts down to zero and stops.
// (R22) Released SCL suspends counting until SCL is sampled high.
// (R23) Event flags are sticky until cleared; reset returns to idle.
`timescale 1ns/1ns

module ims_seq
    import ims_pkg::*;
(
    input wire logic i_clk,                   // System clock, 25 MHz.
    input wire logic i_rst,                   // Synchronous reset, active high.
    input wire logic i_scl_in,                // SCL pin level.
    output logic o_scl_out,                   // SCL output level, always low.
    output logic o_scl_oe,                    // SCL pulled low when high.
    input wire logic i_sda_in,                // SDA pin level.
    output logic o_sda_out,                   // SDA output level, always low.
    output logic o_sda_oe,                    // SDA pulled low when high.
    input wire logic [BAUD_W-1:0] i_baud_reload, // Baud reload value.
    input wire logic i_ctl2_wr,               // Control write strobe.
    input wire logic [CTL2_W-1:0] i_ctl2_wdata, // Control write data.
    input wire logic i_buf_wr,                // Shift buffer write strobe.
    input wire logic [BYTE_W-1:0] i_buf_wdata, // Shift buffer write data.
    input wire logic i_clr_event,             // Clear serial event flag.
    input wire logic i_clr_bcol,              // Clear bus collision flag.
    input wire logic i_clr_write_collision,              // Clear write collision flag.
    output logic o_start_enable,              // Start in progress.
    output logic o_restart_enable,            // Restart in progress.
    output logic o_start_seen,                // Start condition detected.
    output logic o_buffer_full,               // Byte waiting or shifting.
    output logic o_ack_status,                // High when not acknowledged.
    output logic o_serial_event_flag,         // Sequence finished.
    output logic o_bus_collision_flag,        // Collision detected.
    output logic o_write_collision,           // Buffer write was dropped.
    output logic [BYTE_W-1:0] o_shift_buffer  // Shift buffer contents.
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            scl_m_q <= i_scl_in;
            scl_s_q <= scl_m_q;
            sda_m_q <= i_sda_in;
            sda_s_q <= sda_m_q;
        end
    end

    // ****************************************************************
    // Event decode
    // ****************************************************************
    ims_state_t state_q;
    logic scl_oe_q, sda_oe_q;
    logic start_en_q, restart_en_q, sseen_q, bf_q, ack_q;
    logic event_q, bcol_q, write_collision_q;
    logic [BYTE_W-1:0] buf_q, shift_q;
    logic [3:0] bit_cnt_q;
    logic expire, idle, both_hi;
    logic wr_start, wr_restart, buf_take, buf_reject;
    logic col_start, col_restart, bus_col;
    logic ev_sseen, ack_done, ev_done, baud_load;

    assign idle = (state_q == ST_IDLE);
    assign both_hi = sda_s_q && scl_s_q;
    assign wr_start = i_ctl2_wr && idle && i_ctl2_wdata[CTL_START_BIT];          // R6
    assign wr_restart = i_ctl2_wr && idle && !i_ctl2_wdata[CTL_START_BIT]
        && i_ctl2_wdata[CTL_RESTART_BIT];                                       // R10
    assign buf_take = i_buf_wr && idle && !wr_start && !wr_restart;             // R13
    assign buf_reject = i_buf_wr && !buf_take;                                  // R5 R12 R19
    assign col_start = (wr_start && !both_hi)
        || ((state_q == ST_S_WAIT) && (!scl_s_q || (expire && !sda_s_q)));     // R4
    assign col_restart = ((state_q == ST_R_SDAHI) && expire && !sda_s_q)
        || ((state_q == ST_R_SCLREL) && scl_s_q && !sda_s_q)
        || ((state_q == ST_R_BOTHHI) && !both_hi);                              // R11
    assign bus_col = col_start || col_restart;
    assign ev_sseen = expire && both_hi
        && ((state_q == ST_S_WAIT) || (state_q == ST_R_BOTHHI));                // R2 R9
    assign ack_done = (state_q == ST_T_HIGH) && expire && (bit_cnt_q == BITS_PER_BYTE);
    assign ev_done = expire && ((state_q == ST_S_HOLD) || (state_q == ST_R_SDALO))
        || ack_done;
    assign baud_load = (wr_start && both_hi)                                    // R1
        || (ev_sseen && !bus_col)                                               // R3
        || ((state_q == ST_R_SCLLO) && !scl_s_q)                                // R7
        || ((state_q == ST_R_SCLREL) && scl_s_q && sda_s_q)                     // R8
        || buf_take                                                             // R13
        || ((state_q == ST_T_REL) && scl_s_q)                                   // R22
        || ((state_q == ST_T_HIGH) && expire && !ack_done);                     // R14

    ims_baud #(
        .W(BAUD_W)
    ) u_baud (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_load(baud_load),
        .i_stop(bus_col),
        .i_reload(i_baud_reload),
        .o_expire(expire)
    );

    // ****************************************************************
    // Sequencer and pin drive
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= ST_IDLE;                                                 // R23
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            bit_cnt_q <= BIT_CNT_RST;
            shift_q <= BUF_RST;
        end else if (bus_col) begin
            state_q <= ST_IDLE;                                                 // R4 R11
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (wr_start) begin
                        state_q <= ST_S_WAIT;                                   // R1
                    end else if (wr_restart) begin
                        scl_oe_q <= 1'b1;                                       // R7
                        state_q <= ST_R_SCLLO;
                    end else if (buf_take) begin
                        scl_oe_q <= 1'b1;                                       // R14
                        sda_oe_q <= !i_buf_wdata[BYTE_W-1];
                        shift_q <= {i_buf_wdata[BYTE_W-2:0], 1'b0};
                        bit_cnt_q <= BIT_CNT_RST;
                        state_q <= ST_T_LOW;
                    end
                end
                ST_S_WAIT: begin
                    if (expire) begin
                        sda_oe_q <= 1'b1;                                       // R2
                        state_q <= ST_S_HOLD;
                    end
                end
                ST_S_HOLD: begin
                    if (expire) begin
                        state_q <= ST_IDLE;                                     // R3
                    end
                end
                ST_R_SCLLO: begin
                    if (!scl_s_q) begin
                        sda_oe_q <= 1'b0;                                       // R7
                        state_q <= ST_R_SDAHI;
                    end
                end
                ST_R_SDAHI: begin
                    if (expire) begin
                        scl_oe_q <= 1'b0;                                       // R8
                        state_q <= ST_R_SCLREL;
                    end
                end
                ST_R_SCLREL: begin
                    if (scl_s_q) begin
                        state_q <= ST_R_BOTHHI;                                 // R8 R22
                    end
                end
                ST_R_BOTHHI: begin
                    if (expire) begin
                        sda_oe_q <= 1'b1;                                       // R8
                        state_q <= ST_R_SDALO;
                    end
                end
                ST_R_SDALO: begin
                    if (expire) begin
                        state_q <= ST_IDLE;                                     // R9
                    end
                end
                ST_T_LOW: begin
                    if (expire) begin
                        scl_oe_q <= 1'b0;                                       // R14
                        state_q <= ST_T_REL;
                    end
                end
                ST_T_REL: begin
                    if (scl_s_q) begin
                        state_q <= ST_T_HIGH;                                   // R22
                    end
                end
                ST_T_HIGH: begin
                    if (ack_done) begin
                        scl_oe_q <= 1'b1;                                       // R18
                        sda_oe_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else if (expire) begin
                        scl_oe_q <= 1'b1;                                       // R14
                        bit_cnt_q <= bit_cnt_q + BIT_CNT_ONE;
                        if (bit_cnt_q + BIT_CNT_ONE == BITS_PER_BYTE) begin
                            sda_oe_q <= 1'b0;                                   // R16
                        end else begin
                            sda_oe_q <= !shift_q[BYTE_W-1];
                            shift_q <= {shift_q[BYTE_W-2:0], 1'b0};
                        end
                        state_q <= ST_T_LOW;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    scl_oe_q <= 1'b0;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Control bits and status flags
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            start_en_q <= 1'b0;
            restart_en_q <= 1'b0;
            sseen_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            if (wr_start && both_hi) begin
                start_en_q <= 1'b1;                                             // R1
            end else if (bus_col || ((state_q == ST_S_HOLD) && expire)) begin
                start_en_q <= 1'b0;                                             // R3 R4
            end
            if (wr_restart) begin
                restart_en_q <= 1'b1;                                           // R7
            end else if (bus_col || ((state_q == ST_R_SDALO) && expire)) begin
                restart_en_q <= 1'b0;                                           // R9
            end
            if (ev_sseen && !bus_col) begin
                sseen_q <= 1'b1;                                                // R2 R9
            end
            if (ack_done) begin
                ack_q <= sda_s_q;                                               // R17
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            event_q <= 1'b0;
            bcol_q <= 1'b0;
            write_collision_q <= 1'b0;
        end else begin
            if (ev_done && !bus_col) begin
                event_q <= 1'b1;                                                // R9 R18
            end else if (i_clr_event) begin
                event_q <= 1'b0;                                                // R23
            end
            if (bus_col) begin
                bcol_q <= 1'b1;                                                 // R4 R11
            end else if (i_clr_bcol) begin
                bcol_q <= 1'b0;                                                 // R23
            end
            if (buf_reject) begin
                write_collision_q <= 1'b1;                                                 // R5 R12 R19
            end else if (i_clr_write_collision) begin
                write_collision_q <= 1'b0;                                                 // R19
            end
        end
    end

    // ****************************************************************
    // Shift buffer
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            buf_q <= BUF_RST;
            bf_q <= 1'b0;
        end else begin
            if (buf_take) begin
                buf_q <= i_buf_wdata;                                           // R13
                bf_q <= 1'b1;                                                   // R13
            end else if (bus_col || ((state_q == ST_T_HIGH) && expire
                && (bit_cnt_q + BIT_CNT_ONE == BITS_PER_BYTE))) begin
                bf_q <= 1'b0;                                                   // R15
            end
        end
    end

    assign o_scl_out = 1'b0;
    assign o_sda_out = 1'b0;
    assign o_scl_oe = scl_oe_q;
    assign o_sda_oe = sda_oe_q;
    assign o_start_enable = start_en_q;
    assign o_restart_enable = restart_en_q;
    assign o_start_seen = sseen_q;
    assign o_buffer_full = bf_q;
    assign o_ack_status = ack_q;
    assign o_serial_event_flag = event_q;
    assign o_bus_collision_flag = bcol_q;
    assign o_write_collision = write_collision_q;
    assign o_shift_buffer = buf_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    AST_WRITE_COLLISION_DROP: assert property (buf_reject |=> write_collision_q && $stable(buf_q)) // R5
        else $error("dropped buffer write changed buffer or left write_collision clear");
    AST_BF_SET: assert property (buf_take |=> bf_q && (state_q == ST_T_LOW) && scl_oe_q) // R13
        else $error("accepted buffer write did not start the byte");
    AST_CTL_IGNORE: assert property (i_ctl2_wr && !idle && !restart_en_q |=> !restart_en_q) // R10
        else $error("restart request taken while busy");
    AST_START_LOW: assert property ((state_q == ST_S_WAIT) && expire && both_hi
        |=> sda_oe_q && sseen_q && !scl_oe_q) // R2
        else $error("start did not drive SDA low");
    AST_START_DONE: assert property ((state_q == ST_S_HOLD) && expire
        |=> !start_en_q && sda_oe_q && idle && event_q) // R3
        else $error("start did not complete correctly");
    AST_BCOL_START: assert property ((state_q == ST_S_WAIT) && !scl_s_q
        |=> bcol_q && idle && !sda_oe_q && !scl_oe_q) // R4
        else $error("start collision not handled");
    AST_RESTART_SCL: assert property (wr_restart |=> scl_oe_q [*2]) // R7
        else $error("restart did not pull SCL low");
    AST_ACK: assert property (ack_done |=> (ack_q == $past(sda_s_q)) && event_q
        && scl_oe_q && !sda_oe_q && idle) // R17
        else $error("acknowledge not sampled on ninth clock");
    AST_REL_WAIT: assert property ((state_q == ST_T_REL) && !scl_s_q
        |=> (state_q == ST_T_REL) && !scl_oe_q) // R22
        else $error("high phase counted while SCL held low");
    AST_EVENT_STICKY: assert property (event_q && !i_clr_event |=> event_q) // R23
        else $error("event flag dropped without a clear");

    COV_START: cover property ((state_q == ST_S_HOLD) && expire);
    COV_RESTART: cover property ((state_q == ST_R_SDALO) && expire);
    COV_ACK: cover property (ack_done && !sda_s_q);
    COV_BCOL: cover property (col_restart);
endmodule

// ---- tb/ims_slave.sv ----
// Behavioural I2C slave that collects bytes, acknowledges and stretches SCL.
`timescale 1ns/1ns

module ims_slave (
    input wire logic scl,          // Resolved SCL level.
    input wire logic sda,          // Resolved SDA level.
    input wire logic i_ack,        // Acknowledge received bytes.
    input wire logic i_stretch,    // Hold SCL low after each falling edge.
    input wire logic i_sda_low,    // Hold SDA low to provoke a collision.
    output logic o_sda_oe,         // High while pulling SDA low.
    output logic o_scl_oe,         // High while pulling SCL low.
    output logic [7:0] o_byte      // Last bits collected, MSB first.
);
    int n;
    logic ack_drv;
    initial begin
        n = 0;
        ack_drv = 1'b0;
        o_scl_oe = 1'b0;
        o_byte = 8'h00;
    end
    assign o_sda_oe = ack_drv | i_sda_low;
    // A start or repeated start restarts the bit count.
    always @(negedge sda) begin
        if (scl) begin
            n = 0;
        end
    end
    always @(posedge scl) begin
        if (n < 8) begin
            o_byte = {o_byte[6:0], sda};
            n = n + 1;
        end else begin
            n = 9;
        end
    end
    // The acknowledge is held from the eighth to the ninth falling edge.
    always @(negedge scl) begin
        if (n == 8) begin
            ack_drv = i_ack;
        end else if (n == 9) begin
            ack_drv = 1'b0;
            n = 0;
        end
    end
    always @(negedge scl) begin
        if (i_stretch) begin
            o_scl_oe = 1'b1;
            #400;
            o_scl_oe = 1'b0;
        end
    end
endmodule

// ---- tb/tb_ims_seq.sv ----
// Self-checking bench of the I2C master sequencer.
`timescale 1ns/1ns

module tb_ims_seq;
    import ims_pkg::*;
    logic i_clk = 1'b0, i_rst = 1'b1, i_ctl2_wr = 1'b0, i_buf_wr = 1'b0;
    logic i_clr_event = 1'b0, i_clr_bcol = 1'b0, i_clr_write_collision = 1'b0;
    logic [4:0] i_ctl2_wdata = 5'h00;
    logic [7:0] i_buf_wdata = 8'h00;
    logic s_ack = 1'b1, s_str = 1'b0, s_low = 1'b0, s_scl_low = 1'b0;
    logic scl_o, sda_o;
    logic scl_oe, sda_oe, s_scl_oe, s_sda_oe, start_enable, restart_enable, seen, bf, ackst, evt, bcol, write_collision;
    logic [7:0] sbuf, s_byte;
    wire logic scl = (scl_oe ? scl_o : 1'b1) & ~s_scl_oe & ~s_scl_low;
    wire logic sda = (sda_oe ? sda_o : 1'b1) & ~s_sda_oe;
    wire logic [4:0] w = {bcol, sda_oe, evt, restart_enable, start_enable};
    int fails = 0, checks = 0;
    initial begin
        forever #20 i_clk = ~i_clk;
    end
    ims_seq dut (.i_clk(i_clk), .i_rst(i_rst), .i_scl_in(scl), .o_scl_out(scl_o),
        .o_scl_oe(scl_oe), .i_sda_in(sda), .o_sda_out(sda_o), .o_sda_oe(sda_oe),
        .i_baud_reload(7'h03),
        .i_ctl2_wr(i_ctl2_wr), .i_ctl2_wdata(i_ctl2_wdata), .i_buf_wr(i_buf_wr),
        .i_buf_wdata(i_buf_wdata), .i_clr_event(i_clr_event), .i_clr_bcol(i_clr_bcol),
        .i_clr_write_collision(i_clr_write_collision), .o_start_enable(start_enable), .o_restart_enable(restart_enable),
        .o_start_seen(seen), .o_buffer_full(bf), .o_ack_status(ackst),
        .o_serial_event_flag(evt), .o_bus_collision_flag(bcol), .o_write_collision(write_collision),
        .o_shift_buffer(sbuf));
    ims_slave slave (.scl(scl), .sda(sda), .i_ack(s_ack), .i_stretch(s_str),
        .i_sda_low(s_low), .o_sda_oe(s_sda_oe), .o_scl_oe(s_scl_oe), .o_byte(s_byte));
    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wait_until(input int idx, input logic v);
        int k;
        for (k = 0; k < 3000 && w[idx] !== v; k++) cyc(1);
        if (w[idx] !== v) begin
            fails++;
            $display("ERROR wait %0d expected %b seen %b", idx, v, w[idx]);
            end_of_test();
        end
    endtask
    task automatic ctl(input logic [4:0] d);
        i_ctl2_wr = 1'b1;
        i_ctl2_wdata = d;
        cyc(1);
        i_ctl2_wr = 1'b0;
        cyc(1);
    endtask
    task automatic bufw(input logic [7:0] d);
        i_buf_wr = 1'b1;
        i_buf_wdata = d;
        cyc(1);
        i_buf_wr = 1'b0;
        cyc(1);
    endtask
    task automatic clr();
        {i_clr_event, i_clr_bcol, i_clr_write_collision} = 3'h7;
        cyc(1);
        {i_clr_event, i_clr_bcol, i_clr_write_collision} = 3'h0;
        cyc(1);
        chk("flags", {evt, bcol, write_collision}, 8'h00);
    endtask
    task automatic t_collide();
        s_low = 1'b1;
        cyc(4);
        ctl(5'h01);
        chk("start col", {bcol, start_enable, sda_oe}, 8'h04);
        clr();
        ctl(5'h02);
        wait_until(4, 1'b1);
        chk("restart col", {restart_enable, scl_oe, sda_oe}, 8'h00);
        s_low = 1'b0;
        clr();
        ctl(5'h01);
        s_scl_low = 1'b1;
        wait_until(4, 1'b1);
        chk("scl col", {bcol, start_enable, scl_oe, sda_oe}, 8'h08);
        s_scl_low = 1'b0;
        clr();
    endtask
    task automatic t_start();
        ctl(5'h01);
        chk("sen", start_enable, 8'h01);
        ctl(5'h02);
        chk("ctl refused", restart_enable, 8'h00);
        chk("baud early", sda_oe, 8'h00);
        bufw(8'h3C);
        chk("write_collision start", {write_collision, sbuf}, 9'h100);
        chk("baud expiry", sda_oe, 8'h01);
        wait_until(3, 1'b1);
        chk("start cond", {scl_oe, seen, start_enable}, 8'h03);
        wait_until(0, 1'b0);
        chk("start end", {evt, sda_oe}, 8'h03);
        clr();
    endtask
    task automatic t_byte(input logic [7:0] d, input logic ack, input logic str);
        s_ack = ack;
        s_str = str;
        bufw(d);
        chk("bf set", bf, 8'h01);
        bufw(8'hFF);
        ctl(5'h02);
        chk("write_collision tx", {write_collision, restart_enable, sbuf}, {2'b10, d});
        wait_until(2, 1'b1);
        chk("byte", s_byte, d);
        chk("ack", ackst, {7'h00, ~ack});
        chk("end", {bf, scl_oe, sda_oe}, 8'h02);
        clr();
    endtask
    task automatic t_restart();
        ctl(5'h02);
        chk("rs begin", {restart_enable, scl_oe}, 8'h03);
        bufw(8'h11);
        chk("write_collision rs", {write_collision, sbuf}, 9'h15A);
        wait_until(1, 1'b0);
        chk("rs end", {evt, sda_oe, scl_oe, seen, bcol}, 8'h1A);
        clr();
    endtask
    initial begin
        cyc(12);
        i_rst = 1'b0;
        cyc(3);
        chk("reset", {sda_oe, scl_oe, start_enable, restart_enable, bf, evt, bcol, write_collision}, 8'h00);
        t_collide();
        t_start();
        t_byte(8'hA5, 1'b1, 1'b0);
        t_byte(8'h5A, 1'b0, 1'b1);
        t_restart();
        t_byte(8'h81, 1'b1, 1'b0);
        end_of_test();
    end
endmodule
